// *** rx_mode_pkg.sv ***
// Constants, register map and types for the receiver mode-control and sync-detect bank.
package rx_mode_pkg;
   localparam int ADDR_W = 8;
   // Register indexes; the byte address of each register is four times its index.
   localparam logic [7:0] IDX_CLAMP_CLK = 8'h0f;
   localparam logic [7:0] IDX_OUT_MODE = 8'h10;
   localparam logic [7:0] IDX_SYNC_STAT = 8'h11;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
   localparam logic [ADDR_W-1:0] ADDR_CLAMP_CLK = ADDR_W'(IDX_CLAMP_CLK * 4);
   localparam logic [ADDR_W-1:0] ADDR_OUT_MODE = ADDR_W'(IDX_OUT_MODE * 4);
   localparam logic [ADDR_W-1:0] ADDR_SYNC_STAT = ADDR_W'(IDX_SYNC_STAT * 4);
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = ADDR_W'(IDX_IRQ_STAT * 4);
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = ADDR_W'(IDX_IRQ_MASK * 4);
   // Field positions of clamp_clock_source_config.
   localparam int F_HS_POL = 7;
   localparam int F_COAST_POL = 6;
   localparam int F_CLAMP_SRC = 5;
   localparam int F_CLAMP_LVL = 4;
   localparam int F_CLK_SRC = 3;
   localparam int F_CLAMP_MID_RED = 2;
   // Field positions of output_mode_config.
   localparam int F_CLK_INV = 7;
   localparam int F_PIX_SEL = 6;
   localparam int F_DRIVE_HI = 5;
   localparam int F_DRIVE_LO = 4;
   localparam int F_OUT_OFF = 3;
   localparam int F_DET_POL = 2;
   // Field positions of sync_activity_status; irq bits use the same order.
   localparam int F_HS_ACT = 7;
   localparam int F_GREEN_ACT = 6;
   localparam int F_VS_ACT = 5;
   localparam logic [7:0] RST_CLAMP_CLK = 8'hd0;
   localparam logic [7:0] RST_OUT_MODE = 8'h30;
   localparam logic [7:0] MASK_OUT_MODE = 8'hfc;
   localparam logic [7:0] MASK_ACT = 8'he0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ACT_TIMEOUT_US = 400;
   localparam int ACT_TIMEOUT_CYC = (ACT_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
   localparam int ACT_CNT_W = 17;
   localparam int PIX_W = 24;
   localparam int PLL_DIV_W = 12;
   localparam int PHASE_W = 5;
   typedef enum logic [1:0] {
      DRIVE_LOW = 2'b00,
      DRIVE_MED = 2'b01,
      DRIVE_HIGH = 2'b10
   } drive_level_t;
endpackage

// *** sync_2ff.sv ***
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// *** activity_detect.sv ***
// Edge-driven activity flag with a retriggerable timeout.
`timescale 1ns/1ps
module activity_detect #(
   parameter int TIMEOUT = rx_mode_pkg::ACT_TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sig_s,
   output logic active
);
   logic prev_r;
   logic [1:0] arm_r;
   logic [rx_mode_pkg::ACT_CNT_W-1:0] cnt_r;
   // The synchroniser still holds its reset value for the first cycles after reset, so a
   // pin that idles high would look like an edge; edges are ignored until it has filled.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arm_r <= 2'h0;
      end else if (arm_r != 2'h3) begin
         arm_r <= arm_r + 2'h1;
      end
   end
   // Any edge reloads the window; a line held at either level runs it down to idle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 1'b0;
         cnt_r <= '0;
         active <= 1'b0;
      end else begin
         prev_r <= sig_s;
         if (sig_s != prev_r && arm_r == 2'h3) begin
            cnt_r <= rx_mode_pkg::ACT_CNT_W'(TIMEOUT - 1);
            active <= 1'b1;
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end else begin
            active <= 1'b0;
         end
      end
   end
endmodule

// *** rx_mode_regs.sv ***
// Mode-control and sync-activity register bank with AXI4-Lite access.
`timescale 1ns/1ps
module rx_mode_regs #(
   parameter int ACT_TIMEOUT = rx_mode_pkg::ACT_TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [rx_mode_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rx_mode_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic hsync_pin,
   input wire logic green_embedded_sync,
   input wire logic vsync_pin,
   input wire logic clamp_strobe_pin,
   input wire logic internal_clamp,
   input wire logic digital_mode,
   input wire logic [rx_mode_pkg::PLL_DIV_W-1:0] pll_divide_ratio,
   input wire logic [rx_mode_pkg::PHASE_W-1:0] phase_adjust,
   input wire logic [rx_mode_pkg::PIX_W-1:0] pixel_in,
   input wire logic pixel_valid,
   output logic clamp_active,
   output logic [2:0] clamp_to_midscale,
   output logic pixel_clock_source,
   output logic [rx_mode_pkg::PLL_DIV_W-1:0] pll_divide_applied,
   output logic [rx_mode_pkg::PHASE_W-1:0] phase_applied,
   output logic output_clock_invert,
   output logic [rx_mode_pkg::PIX_W-1:0] even_port,
   output logic [rx_mode_pkg::PIX_W-1:0] odd_port,
   output logic port_strobe,
   output logic [1:0] drive_level,
   output logic data_oe,
   output logic green_sync_output_oe,
   output logic reference_output_oe,
   output logic sync_detect_out,
   output logic irq
);
   logic [7:0] cfg_clamp_r;
   logic [7:0] cfg_out_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic [2:0] act;
   logic [2:0] act_prev_r;
   logic [3:0] pins_s;
   logic [rx_mode_pkg::ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic aw_have_r;
   logic w_have_r;
   logic wr_fire;
   logic rd_fire;
   logic stat_rd_clr;
   logic [31:0] rd_data_nxt;
   logic rd_err_nxt;
   logic pix_phase_r;
   logic [rx_mode_pkg::PIX_W-1:0] pix_hold_r;
   logic [7:0] stat_byte;
   logic any_act;

   // ----------------------------------------------------------------
   // Pin synchronisation and activity detection
   // ----------------------------------------------------------------
   sync_2ff #(.W(4)) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({hsync_pin, green_embedded_sync, vsync_pin, clamp_strobe_pin}),
      .q(pins_s)
   );

   for (genvar i = 0; i < 3; i++) begin : g_act
      activity_detect #(.TIMEOUT(ACT_TIMEOUT)) u_act (
         .aclk(aclk),
         .aresetn(aresetn),
         .sig_s(pins_s[i+1]),
         .active(act[i])
      );
   end

   // act[2] hsync, act[1] green sync, act[0] vsync.
   assign stat_byte = {act, 5'h00};
   assign any_act = |act;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rx_mode_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r == rx_mode_pkg::ADDR_CLAMP_CLK ||
                            aw_addr_r == rx_mode_pkg::ADDR_OUT_MODE ||
                            aw_addr_r == rx_mode_pkg::ADDR_SYNC_STAT ||
                            aw_addr_r == rx_mode_pkg::ADDR_IRQ_STAT ||
                            aw_addr_r == rx_mode_pkg::ADDR_IRQ_MASK) ?
                           rx_mode_pkg::RESP_OKAY : rx_mode_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Only byte lane 0 carries register bits; status registers ignore writes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_clamp_r <= rx_mode_pkg::RST_CLAMP_CLK;
         cfg_out_r <= rx_mode_pkg::RST_OUT_MODE;
         irq_mask_r <= '0;
      end else if (wr_fire && w_strb_r[0]) begin
         if (aw_addr_r == rx_mode_pkg::ADDR_CLAMP_CLK) begin
            cfg_clamp_r <= w_data_r[7:0];
         end
         if (aw_addr_r == rx_mode_pkg::ADDR_OUT_MODE) begin
            cfg_out_r <= w_data_r[7:0] & rx_mode_pkg::MASK_OUT_MODE;
         end
         if (aw_addr_r == rx_mode_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= w_data_r[rx_mode_pkg::F_HS_ACT:rx_mode_pkg::F_VS_ACT];
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign stat_rd_clr = rd_fire && s_axi_araddr == rx_mode_pkg::ADDR_IRQ_STAT;

   always_comb begin
      rd_data_nxt = '0;
      rd_err_nxt = 1'b0;
      unique case (s_axi_araddr)
         rx_mode_pkg::ADDR_CLAMP_CLK: rd_data_nxt[7:0] = cfg_clamp_r;
         rx_mode_pkg::ADDR_OUT_MODE: rd_data_nxt[7:0] = cfg_out_r;
         rx_mode_pkg::ADDR_SYNC_STAT: rd_data_nxt[7:0] = stat_byte;
         rx_mode_pkg::ADDR_IRQ_STAT: rd_data_nxt[7:0] = {irq_stat_r, 5'h00};
         rx_mode_pkg::ADDR_IRQ_MASK: rd_data_nxt[7:0] = {irq_mask_r, 5'h00};
         default: rd_err_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= rx_mode_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_nxt;
            s_axi_rresp <= rd_err_nxt ? rx_mode_pkg::RESP_SLVERR : rx_mode_pkg::RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts: any change of an activity flag is an event
   // ----------------------------------------------------------------
   // A change in the same cycle as the clearing read stays set, so no event is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_prev_r <= '0;
         irq_stat_r <= '0;
         irq <= 1'b0;
      end else begin
         act_prev_r <= act;
         irq_stat_r <= (stat_rd_clr ? 3'h0 : irq_stat_r) | (act ^ act_prev_r);
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ----------------------------------------------------------------
   // Clamp and clock source control
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clamp_active <= 1'b0;
         clamp_to_midscale <= '0;
         pixel_clock_source <= 1'b0;
         pll_divide_applied <= '0;
         phase_applied <= '0;
      end else begin
         if (cfg_clamp_r[rx_mode_pkg::F_CLAMP_SRC]) begin
            clamp_active <= pins_s[0] ^ cfg_clamp_r[rx_mode_pkg::F_CLAMP_LVL];
         end else begin
            clamp_active <= internal_clamp;
         end
         clamp_to_midscale <= cfg_clamp_r[rx_mode_pkg::F_CLAMP_MID_RED -: 3];
         pixel_clock_source <= cfg_clamp_r[rx_mode_pkg::F_CLK_SRC];
         // The divider holds its last internal-mode ratio so a switch back is glitch free.
         if (!cfg_clamp_r[rx_mode_pkg::F_CLK_SRC]) begin
            pll_divide_applied <= pll_divide_ratio;
         end
         phase_applied <= phase_adjust;
      end
   end

   // ----------------------------------------------------------------
   // Output formatting, drive and enables
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_clock_invert <= 1'b0;
         drive_level <= rx_mode_pkg::DRIVE_HIGH;
         data_oe <= 1'b0;
         green_sync_output_oe <= 1'b0;
         reference_output_oe <= 1'b0;
         sync_detect_out <= 1'b0;
      end else begin
         output_clock_invert <= digital_mode && cfg_out_r[rx_mode_pkg::F_CLK_INV];
         if (cfg_out_r[rx_mode_pkg::F_DRIVE_HI]) begin
            drive_level <= rx_mode_pkg::DRIVE_HIGH;
         end else if (cfg_out_r[rx_mode_pkg::F_DRIVE_LO]) begin
            drive_level <= rx_mode_pkg::DRIVE_MED;
         end else begin
            drive_level <= rx_mode_pkg::DRIVE_LOW;
         end
         data_oe <= !cfg_out_r[rx_mode_pkg::F_OUT_OFF];
         green_sync_output_oe <= 1'b1;
         reference_output_oe <= 1'b1;
         sync_detect_out <= any_act ^ cfg_out_r[rx_mode_pkg::F_DET_POL];
      end
   end

   // Two-pixel mode buffers the first pixel so both ports change together.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pix_phase_r <= 1'b0;
         pix_hold_r <= '0;
         even_port <= '0;
         odd_port <= '0;
         port_strobe <= 1'b0;
      end else begin
         port_strobe <= 1'b0;
         if (!digital_mode || !cfg_out_r[rx_mode_pkg::F_PIX_SEL]) begin
            pix_phase_r <= 1'b0;
         end
         if (digital_mode && pixel_valid) begin
            if (!cfg_out_r[rx_mode_pkg::F_PIX_SEL]) begin
               even_port <= pixel_in;
               port_strobe <= 1'b1;
            end else if (!pix_phase_r) begin
               pix_hold_r <= pixel_in;
               pix_phase_r <= 1'b1;
            end else begin
               even_port <= pix_hold_r;
               odd_port <= pixel_in;
               port_strobe <= 1'b1;
               pix_phase_r <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_clamp_ext_pol: assert property (
      cfg_clamp_r[rx_mode_pkg::F_CLAMP_SRC] |=>
      clamp_active == ($past(pins_s[0]) ^ $past(cfg_clamp_r[rx_mode_pkg::F_CLAMP_LVL])))
      else $error("clamp does not follow strobe polarity");
   a_clamp_lvl_rst: assert property (
      $rose(aresetn) |-> cfg_clamp_r[rx_mode_pkg::F_CLAMP_LVL] && !cfg_clamp_r[rx_mode_pkg::F_CLK_SRC])
      else $error("clamp config reset value wrong");
   a_clk_src_out: assert property (
      ##1 pixel_clock_source == $past(cfg_clamp_r[rx_mode_pkg::F_CLK_SRC]))
      else $error("clock source select not applied");
   a_pll_div_hold: assert property (
      $past(cfg_clamp_r[rx_mode_pkg::F_CLK_SRC]) |-> $stable(pll_divide_applied))
      else $error("divide ratio changed with external clock");
   a_clamp_target: assert property (
      ##1 clamp_to_midscale == $past(cfg_clamp_r[2:0]))
      else $error("clamp target mismatch");
   a_clk_inv_mode: assert property (
      !$past(digital_mode) |-> !output_clock_invert)
      else $error("clock invert outside digital mode");
   a_pix_one_mode: assert property (
      digital_mode && pixel_valid && !cfg_out_r[rx_mode_pkg::F_PIX_SEL] |=>
      port_strobe && even_port == $past(pixel_in))
      else $error("single pixel mode did not pass pixel");
   a_drive_decode: assert property (
      cfg_out_r[rx_mode_pkg::F_DRIVE_HI] |=> drive_level == rx_mode_pkg::DRIVE_HIGH)
      else $error("drive decode wrong");
   a_outputs_off: assert property (
      cfg_out_r[rx_mode_pkg::F_OUT_OFF] |=> !data_oe && green_sync_output_oe && reference_output_oe)
      else $error("outputs off enables wrong");
   a_detect_pol: assert property (
      ##1 sync_detect_out == ($past(any_act) ^ $past(cfg_out_r[rx_mode_pkg::F_DET_POL])))
      else $error("sync detect polarity wrong");
   a_hs_edge_act: assert property (
      $past(aresetn, 3) && $changed(pins_s[3]) |-> ##1 act[2])
      else $error("hsync edge did not set activity");
   a_green_edge_act: assert property (
      $past(aresetn, 3) && $changed(pins_s[2]) |-> ##1 act[1] [*2])
      else $error("green sync edge did not set activity");
   a_vs_stat_bit: assert property (
      rd_fire && s_axi_araddr == rx_mode_pkg::ADDR_SYNC_STAT |=>
      s_axi_rdata[rx_mode_pkg::F_VS_ACT] == $past(act[0]))
      else $error("vsync status bit wrong");
   a_clamp_internal: assert property (
      !cfg_clamp_r[rx_mode_pkg::F_CLAMP_SRC] |=> clamp_active == $past(internal_clamp))
      else $error("internal clamp not used");
   a_irq_sticky: assert property (
      (act != act_prev_r) |=> irq_stat_r != 3'h0)
      else $error("activity change lost");

   c_ext_clamp: cover property (cfg_clamp_r[rx_mode_pkg::F_CLAMP_SRC] && clamp_active);
   c_two_pixel: cover property (cfg_out_r[rx_mode_pkg::F_PIX_SEL] && port_strobe);
   c_irq_high: cover property (irq);
   c_all_active: cover property (&act);
endmodule

// *** sync_src.sv ***
// Behavioural video source driving the sync and clamp strobe pins.
`timescale 1ns/1ps
module sync_src (
   input wire logic aclk,
   input wire logic [2:0] run,
   input wire logic strobe,
   output logic hsync_pin,
   output logic green_embedded_sync,
   output logic vsync_pin,
   output logic clamp_strobe_pin
);
   // ---------------------------------------------------------------
   // Sync toggling
   // ---------------------------------------------------------------
   logic [2:0] lvl_r = 3'h0;
   logic [2:0] cnt_r = 3'h0;
   // A stopped line keeps its last level, which must read as no activity.
   // The toggle period of eight cycles stays inside the short bench timeout.
   always_ff @(posedge aclk) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h0) begin
         lvl_r <= lvl_r ^ run;
      end
   end
   assign hsync_pin = lvl_r[2];
   assign green_embedded_sync = lvl_r[1];
   assign vsync_pin = lvl_r[0];
   assign clamp_strobe_pin = strobe;
endmodule

// *** tb_top.sv ***
// Self-checking bench for the mode-control and sync-detect register bank.
`timescale 1ns/1ps
module tb_top;
   localparam int TMO = 16;
   localparam logic [7:0] A_CC = rx_mode_pkg::ADDR_CLAMP_CLK;
   localparam logic [7:0] A_OM = rx_mode_pkg::ADDR_OUT_MODE;
   localparam logic [7:0] A_SS = rx_mode_pkg::ADDR_SYNC_STAT;
   localparam logic [7:0] A_IS = rx_mode_pkg::ADDR_IRQ_STAT;
   localparam logic [7:0] A_IM = rx_mode_pkg::ADDR_IRQ_MASK;
   localparam logic [1:0] OK = rx_mode_pkg::RESP_OKAY;
   localparam logic [1:0] SLV = rx_mode_pkg::RESP_SLVERR;
   localparam logic [7:0] CL_CFG [6] = '{8'hf0, 8'hf0, 8'he0, 8'he0, 8'hd0, 8'hd0};
   localparam logic [1:0] CL_IN [6] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h3, 2'h2};
   localparam logic [5:0] CL_EXP = 6'h16;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic internal_clamp = 1'b0, digital_mode = 1'b0, pixel_valid = 1'b0, strobe = 1'b0;
   logic [11:0] pll_divide_ratio = 12'h0ff;
   logic [4:0] phase_adjust = 5'h00;
   logic [23:0] pixel_in = 24'h0;
   logic [2:0] run = 3'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, drive_level;
   logic [31:0] s_axi_rdata;
   logic hsync_pin, green_embedded_sync, vsync_pin, clamp_strobe_pin, clamp_active;
   logic [2:0] clamp_to_midscale;
   logic pixel_clock_source, output_clock_invert, port_strobe, data_oe;
   logic green_sync_output_oe, reference_output_oe, sync_detect_out, irq;
   logic [11:0] pll_divide_applied;
   logic [4:0] phase_applied;
   logic [23:0] even_port, odd_port;
   int miscompares = 0;
   int num_checks = 0;
   always #2.5 aclk = ~aclk;
   rx_mode_regs #(.ACT_TIMEOUT(TMO)) u_rx_mode_regs (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .hsync_pin, .green_embedded_sync, .vsync_pin,
      .clamp_strobe_pin, .internal_clamp, .digital_mode, .pll_divide_ratio, .phase_adjust,
      .pixel_in, .pixel_valid, .clamp_active, .clamp_to_midscale, .pixel_clock_source,
      .pll_divide_applied, .phase_applied, .output_clock_invert, .even_port, .odd_port,
      .port_strobe, .drive_level, .data_oe, .green_sync_output_oe, .reference_output_oe,
      .sync_detect_out, .irq);
   sync_src u_sync_src (.aclk, .run, .strobe, .hsync_pin, .green_embedded_sync, .vsync_pin,
      .clamp_strobe_pin);
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 40) begin
         miscompares++;
         $display("unexpected at %0t: wait ran out", $time);
         report_and_stop();
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Each bus task lets one edge pass at its end so no signal is driven twice at once.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      tmo(i);
      chk(64'(s_axi_bresp), 64'(er));
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      tmo(i);
      chk(64'({s_axi_rdata, s_axi_rresp}), 64'({24'h0, e, er}));
      @(posedge aclk);
   endtask
   task automatic pix(input logic [23:0] d);
      pixel_in <= d;
      pixel_valid <= 1'b1;
      @(posedge aclk);
   endtask
   task automatic wstrobe();
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (port_strobe) break;
      end
      tmo(i);
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      tick(3);
      chk(64'({drive_level, data_oe, green_sync_output_oe, reference_output_oe,
         pixel_clock_source, clamp_to_midscale, sync_detect_out, irq}), 64'h5c0);
      rd(A_CC, 8'hd0, OK);
      rd(A_OM, 8'h30, OK);
      rd(A_SS, 8'h00, OK);
      rd(8'h08, 8'h00, SLV);
      for (int k = 0; k < 6; k++) begin
         wr(A_CC, CL_CFG[k], OK);
         strobe <= CL_IN[k][1];
         internal_clamp <= CL_IN[k][0];
         tick(8);
         chk(64'(clamp_active), 64'(CL_EXP[k]));
      end
      wr(A_CC, 8'hdd, OK);
      pll_divide_ratio <= 12'h123;
      phase_adjust <= 5'h0a;
      tick(4);
      chk(64'({clamp_to_midscale, pixel_clock_source}), 64'hb);
      chk(64'({pll_divide_applied, phase_applied}), 64'({12'h0ff, 5'h0a}));
      rd(A_CC, 8'hdd, OK);
      wr(A_CC, 8'hd2, OK);
      tick(3);
      chk(64'({clamp_to_midscale, pixel_clock_source, pll_divide_applied}), 64'h4123);
      for (int j = 0; j < 4; j++) begin
         wr(A_OM, 8'(j * 16), OK);
         tick(2);
         chk(64'(drive_level), (j > 1) ? 64'h2 : 64'(j));
      end
      wr(A_OM, 8'h8f, OK);
      rd(A_OM, 8'h8c, OK);
      chk(64'({data_oe, green_sync_output_oe, reference_output_oe, output_clock_invert,
         sync_detect_out}), 64'h0d);
      digital_mode <= 1'b1;
      tick(2);
      chk(64'(output_clock_invert), 64'h1);
      wr(A_OM, 8'h00, OK);
      pix(24'habcdef);
      pixel_valid <= 1'b0;
      wstrobe();
      chk(64'(even_port), 64'habcdef);
      wr(A_OM, 8'h40, OK);
      pix(24'h111111);
      pix(24'h222222);
      pixel_valid <= 1'b0;
      wstrobe();
      chk(64'({even_port, odd_port}), 64'h111111222222);
      for (int b = 0; b < 3; b++) begin
         wr(A_OM, (b == 1) ? 8'h04 : 8'h00, OK);
         run <= 3'h4 >> b;
         tick(20);
         rd(A_SS, 8'h80 >> b, OK);
         chk(64'({sync_detect_out, irq}), (b == 1) ? 64'h0 : 64'h2);
         run <= 3'h0;
         tick(40);
         rd(A_SS, 8'h00, OK);
      end
      rd(A_IS, 8'he0, OK);
      wr(A_IM, 8'h80, OK);
      rd(A_IM, 8'h80, OK);
      run <= 3'h7;
      tick(20);
      chk(64'(irq), 64'h1);
      wr(A_SS, 8'hff, OK);
      rd(A_SS, 8'he0, OK);
      rd(A_IS, 8'he0, OK);
      tick(2);
      chk(64'(irq), 64'h0);
      wr(8'h08, 8'h55, SLV);
      report_and_stop();
   end
endmodule
